// ===== vms_pkg.sv
package vms_pkg;

   // ----------------------------------------------------------------
   // I/O port map (10-bit I/O channel address)
   // ----------------------------------------------------------------
   localparam logic [9:0] PORT_MODE_SELECT  = 10'h3D8;
   localparam logic [9:0] PORT_COLOR_SELECT = 10'h3D9;
   localparam logic [9:0] PORT_STATUS       = 10'h3DA;
   localparam logic [9:0] PORT_PEN_CLEAR    = 10'h3DB;
   localparam logic [9:0] PORT_PEN_PRESET   = 10'h3DC;

   // ----------------------------------------------------------------
   // Mode-select field positions
   // ----------------------------------------------------------------
   localparam int MODE_COLS80   = 0;
   localparam int MODE_GRAPHICS = 1;
   localparam int MODE_MONO     = 2;
   localparam int MODE_VIDEO_EN = 3;
   localparam int MODE_HIRES    = 4;
   localparam int MODE_BLINK    = 5;
   localparam int MODE_WIDTH    = 6;
   localparam int COLOR_WIDTH   = 6;

   // ----------------------------------------------------------------
   // Status field positions and reset values
   // ----------------------------------------------------------------
   localparam int STAT_ACCESS_OK = 0;
   localparam int STAT_PEN_TRIG  = 1;
   localparam int STAT_PEN_SW    = 2;
   localparam int STAT_VRETRACE  = 3;
   localparam logic [5:0] MODE_RESET  = 6'h00;
   localparam logic [5:0] COLOR_RESET = 6'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Regeneration buffer window in host memory space
   // ----------------------------------------------------------------
   localparam logic [19:0] REGEN_BASE  = 20'hB_8000;
   localparam logic [19:0] REGEN_LIMIT = 20'hB_C000;
   localparam int          REGEN_AW    = 14;

   // Host I/O cycle, one-cycle strobes
   typedef struct packed {
      logic [9:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } vms_io_req_t;

   // Host memory cycle, one-cycle strobes
   typedef struct packed {
      logic [19:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } vms_mem_req_t;

   // Decoded display mode
   typedef struct packed {
      logic       cols80;
      logic       graphics;
      logic       mono;
      logic       video_en;
      logic       hires;
      logic       blink;
      logic [5:0] color_sel;
   } vms_mode_t;

endpackage : vms_pkg

// ===== vms_regen_ram.sv
`timescale 1ns/1ns

// Regeneration buffer: one host port, one display read port
module vms_regen_ram #(
   parameter int AW = 14,
   parameter int DW = 8
) (
   // Clock
   input  wire logic          clk_in,
   // Host port
   input  wire logic          host_en_in,
   input  wire logic          host_wr_in,
   input  wire logic [AW-1:0] host_addr_in,
   input  wire logic [DW-1:0] host_wdata_in,
   output      logic [DW-1:0] host_rdata_out,
   // Display fetch port
   input  wire logic [AW-1:0] disp_addr_in,
   output      logic [DW-1:0] disp_rdata_out
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Host write and registered read; no parity is kept
   always_ff @(posedge clk_in) begin
      if (host_en_in && host_wr_in) begin
         mem[host_addr_in] <= host_wdata_in;
      end
      if (host_en_in && !host_wr_in) begin
         host_rdata_out <= mem[host_addr_in];
      end
   end

   // Display fetch every cycle, old data on a same-address write
   always_ff @(posedge clk_in) begin
      disp_rdata_out <= mem[disp_addr_in];
   end

endmodule : vms_regen_ram

// ===== vms_video_regs.sv
`timescale 1ns/1ns

module vms_video_regs #(
   parameter int REGEN_AW = vms_pkg::REGEN_AW
) (
   // Clock and reset
   input  wire logic                  clk_in,
   input  wire logic                  rst_in,
   // Host I/O and memory cycles
   input  wire vms_pkg::vms_io_req_t  io_req_in,
   input  wire vms_pkg::vms_mem_req_t mem_req_in,
   output      logic [7:0]            io_rdata_out,
   output      logic                  io_rvalid_out,
   output      logic [7:0]            mem_rdata_out,
   output      logic                  mem_rvalid_out,
   // Raster timing from the CRT controller
   input  wire logic                  crt_active_in,
   input  wire logic                  crt_vretrace_in,
   input  wire logic [REGEN_AW-1:0]   disp_addr_in,
   output      logic [7:0]            disp_rdata_out,
   // Light pen pins
   input  wire logic                  pen_trigger_in,
   input  wire logic                  pen_switch_n_in,
   // Display mode
   output      vms_pkg::vms_mode_t    mode_out
);

   // ----------------------------------------------------------------
   // Pin synchronisers and address decode
   // ----------------------------------------------------------------
   logic [1:0] pen_trig_sync;
   logic [1:0] pen_sw_sync;
   logic       pen_trig_prev;
   logic       pen_rise;
   logic       pen_latch;
   logic [5:0] mode_reg;
   logic [5:0] color_reg;
   logic       wr_mode;
   logic       wr_color;
   logic       wr_pen_clear;
   logic       wr_pen_preset;
   logic       rd_status;
   logic       mem_hit;
   logic [7:0] status_byte;

   // Two stages ahead of any logic; pins are asynchronous
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pen_trig_sync <= 2'h0;
         pen_sw_sync   <= 2'h3;
         pen_trig_prev <= 1'b0;
      end else begin
         pen_trig_sync <= {pen_trig_sync[0], pen_trigger_in};
         pen_sw_sync   <= {pen_sw_sync[0], pen_switch_n_in};
         pen_trig_prev <= pen_trig_sync[1];
      end
   end

   // Edge seen only after the second stage
   assign pen_rise = pen_trig_sync[1] & ~pen_trig_prev;

   // Port decode on the full ten address bits
   assign wr_mode       = io_req_in.wr &&
                          io_req_in.addr == vms_pkg::PORT_MODE_SELECT;
   assign wr_color      = io_req_in.wr &&
                          io_req_in.addr == vms_pkg::PORT_COLOR_SELECT;
   assign wr_pen_clear  = io_req_in.wr &&
                          io_req_in.addr == vms_pkg::PORT_PEN_CLEAR;
   assign wr_pen_preset = io_req_in.wr &&
                          io_req_in.addr == vms_pkg::PORT_PEN_PRESET;
   assign rd_status     = io_req_in.rd &&
                          io_req_in.addr == vms_pkg::PORT_STATUS;

   // Buffer window; upper bound exclusive
   assign mem_hit = mem_req_in.addr >= vms_pkg::REGEN_BASE &&
                    mem_req_in.addr <  vms_pkg::REGEN_LIMIT;

   // ----------------------------------------------------------------
   // Write-only mode and colour registers
   // ----------------------------------------------------------------
   // Software is trusted to follow the mode-change order; no readback
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mode_reg  <= vms_pkg::MODE_RESET;
         color_reg <= vms_pkg::COLOR_RESET;
      end else begin
         if (wr_mode) begin
            mode_reg <= io_req_in.wdata[5:0];
         end
         if (wr_color) begin
            color_reg <= io_req_in.wdata[5:0];
         end
      end
   end

   // Decoded mode outputs, registered so they come from flops
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mode_out <= '0;
      end else begin
         mode_out.cols80    <= mode_reg[vms_pkg::MODE_COLS80];
         mode_out.graphics  <= mode_reg[vms_pkg::MODE_GRAPHICS];
         mode_out.mono      <= mode_reg[vms_pkg::MODE_MONO];
         mode_out.video_en  <= mode_reg[vms_pkg::MODE_VIDEO_EN];
         mode_out.hires     <= mode_reg[vms_pkg::MODE_HIRES];
         // Blink only means something in alphanumeric modes
         mode_out.blink     <= mode_reg[vms_pkg::MODE_BLINK] &
                               ~mode_reg[vms_pkg::MODE_GRAPHICS];
         mode_out.color_sel <= color_reg;
      end
   end

   // Mode bits reach the outputs two edges after the write
   AST_VIDEO_EN: assert property (
      @(posedge clk_in) disable iff (rst_in)
      wr_mode |-> ##2 mode_out.video_en ==
         $past(io_req_in.wdata[vms_pkg::MODE_VIDEO_EN], 2))
      else $error("video enable does not follow mode write");
   AST_HIRES: assert property (
      @(posedge clk_in) disable iff (rst_in)
      wr_mode |-> ##2 mode_out.hires ==
         $past(io_req_in.wdata[vms_pkg::MODE_HIRES], 2))
      else $error("hires bit does not follow mode write");
   AST_BLINK: assert property (
      @(posedge clk_in) disable iff (rst_in)
      mode_out.blink |-> !mode_out.graphics)
      else $error("blink active in graphics mode");
   AST_MODE_HOLD: assert property (
      @(posedge clk_in) disable iff (rst_in)
      !wr_mode |=> mode_reg == $past(mode_reg))
      else $error("mode register changed without write");

   // ----------------------------------------------------------------
   // Light-pen latch and status port
   // ----------------------------------------------------------------
   // Set and preset win over clear so no pen edge is lost
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pen_latch <= 1'b0;
      end else if (pen_rise || wr_pen_preset) begin
         pen_latch <= 1'b1;
      end else if (wr_pen_clear) begin
         pen_latch <= 1'b0;
      end
   end

   // Preset is checked through a status read after one quiet edge
   AST_PEN_SET: assert property (
      @(posedge clk_in) disable iff (rst_in)
      $rose(pen_trig_sync[1]) |=> pen_latch)
      else $error("pen edge not latched");
   AST_PEN_CLEAR: assert property (
      @(posedge clk_in) disable iff (rst_in)
      wr_pen_clear && !pen_rise && !wr_pen_preset |=> !pen_latch)
      else $error("pen latch not cleared");
   AST_PEN_PRESET: assert property (
      @(posedge clk_in) disable iff (rst_in)
      wr_pen_preset ##1 !wr_pen_clear ##1 rd_status |=> io_rdata_out[1])
      else $error("preset not visible in status");

   // Status byte; access-safe is the inverse of active display
   assign status_byte = {4'h0,
                         crt_vretrace_in,
                         pen_sw_sync[1],
                         pen_latch,
                         ~crt_active_in};

   // Read data held until the next read; unmapped reads give zero
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         io_rdata_out  <= vms_pkg::RDATA_RESET;
         io_rvalid_out <= 1'b0;
      end else begin
         io_rvalid_out <= io_req_in.rd;
         if (io_req_in.rd) begin
            io_rdata_out <= rd_status ? status_byte :
                            vms_pkg::RDATA_RESET;
         end
      end
   end

   // Every read answers with zero upper bits; status tracks its inputs
   AST_STAT_UPPER: assert property (
      @(posedge clk_in) disable iff (rst_in)
      io_rvalid_out |-> io_rdata_out[7:4] == 4'h0)
      else $error("status upper bits not zero");
   AST_ACCESS_OK: assert property (
      @(posedge clk_in) disable iff (rst_in)
      rd_status |=> io_rdata_out[0] == !$past(crt_active_in))
      else $error("access-safe bit wrong");
   AST_PEN_SW: assert property (
      @(posedge clk_in) disable iff (rst_in)
      rd_status |=> io_rdata_out[2] == $past(pen_sw_sync[1]))
      else $error("pen switch bit wrong");
   AST_VRETRACE: assert property (
      @(posedge clk_in) disable iff (rst_in)
      rd_status |=> io_rdata_out[3] == $past(crt_vretrace_in))
      else $error("retrace bit wrong");

   // ----------------------------------------------------------------
   // Regeneration buffer
   // ----------------------------------------------------------------
   vms_regen_ram #(
      .AW (REGEN_AW),
      .DW (8)
   ) u_ram (
      .clk_in         (clk_in),
      .host_en_in     (mem_hit && (mem_req_in.wr || mem_req_in.rd)),
      .host_wr_in     (mem_req_in.wr),
      .host_addr_in   (mem_req_in.addr[REGEN_AW-1:0]),
      .host_wdata_in  (mem_req_in.wdata),
      .host_rdata_out (mem_rdata_out),
      .disp_addr_in   (disp_addr_in),
      .disp_rdata_out (disp_rdata_out)
   );

   // Valid only for reads inside the window
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mem_rvalid_out <= 1'b0;
      end else begin
         mem_rvalid_out <= mem_hit && mem_req_in.rd && !mem_req_in.wr;
      end
   end

   // The first address past the window must not answer
   AST_MEM_WINDOW: assert property (
      @(posedge clk_in) disable iff (rst_in)
      mem_req_in.rd && !mem_req_in.wr &&
      mem_req_in.addr == vms_pkg::REGEN_LIMIT |=> !mem_rvalid_out)
      else $error("read answered above buffer window");

endmodule : vms_video_regs

// ===== vms_host_model.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Host processor model: one-cycle I/O and memory strobes
// ----------------------------------------------------------------
module vms_host_model (
   // Clock
   input  wire logic                  clk_in,
   // Host cycles toward the adapter
   output      vms_pkg::vms_io_req_t  io_req_out,
   output      vms_pkg::vms_mem_req_t mem_req_out
);
   // Bus idle at time zero
   initial begin
      io_req_out  = '0;
      mem_req_out = '0;
   end

   // One cycle: strobe held over exactly one sampling edge
   task automatic cycle(input logic mem, input logic [19:0] a,
                        input logic [7:0] d, input logic wr);
      @(posedge clk_in);
      #1;
      if (mem)
         mem_req_out = {a, d, wr, ~wr};
      else
         io_req_out = {a[9:0], d, wr, ~wr};
      @(posedge clk_in);
      #1;
      // Released lines flip, so a stale address can never pass as live
      io_req_out  = {~io_req_out.addr, ~io_req_out.wdata, 2'b00};
      mem_req_out = {~mem_req_out.addr, ~mem_req_out.wdata, 2'b00};
   endtask : cycle
endmodule : vms_host_model

// ===== tb_top.sv
`timescale 1ns/1ns

module tb_top;
   // ----------------------------------------------------------------
   // Clock, reset, pins and bookkeeping
   // ----------------------------------------------------------------
   logic                  clk_in = 1'b0;
   logic                  rst_in = 1'b1;
   logic                  crt_active = 1'b0;
   logic                  crt_vretrace = 1'b0;
   logic [13:0]           disp_addr = 14'h0000;
   logic                  pen_trigger = 1'b0;
   logic                  pen_switch_n = 1'b1;
   vms_pkg::vms_io_req_t  io_req;
   vms_pkg::vms_mem_req_t mem_req;
   logic [7:0]            io_rdata;
   logic [7:0]            mem_rdata;
   logic [7:0]            disp_rdata;
   logic                  io_rvalid;
   logic                  mem_rvalid;
   vms_pkg::vms_mode_t    mode;
   logic [7:0]            st;
   int                    n_errors = 0;
   int                    checks = 0;
   int                    cycles = 0;
   logic [7:0]            modes [8] = '{8'h0D, 8'h05, 8'h2D, 8'h25,
                                        8'h1C, 8'h15, 8'h1E, 8'hEA};

   always #50 clk_in = ~clk_in;

   vms_host_model i_vms_host_model (
      .clk_in      (clk_in),
      .io_req_out  (io_req),
      .mem_req_out (mem_req)
   );

   vms_video_regs i_vms_video_regs (
      .clk_in          (clk_in),
      .rst_in          (rst_in),
      .io_req_in       (io_req),
      .mem_req_in      (mem_req),
      .io_rdata_out    (io_rdata),
      .io_rvalid_out   (io_rvalid),
      .mem_rdata_out   (mem_rdata),
      .mem_rvalid_out  (mem_rvalid),
      .crt_active_in   (crt_active),
      .crt_vretrace_in (crt_vretrace),
      .disp_addr_in    (disp_addr),
      .disp_rdata_out  (disp_rdata),
      .pen_trigger_in  (pen_trigger),
      .pen_switch_n_in (pen_switch_n),
      .mode_out        (mode)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [11:0] seen,
                        input logic [11:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   task automatic wr_io(input logic [9:0] a, input logic [7:0] d);
      i_vms_host_model.cycle(1'b0, {10'h000, a}, d, 1'b1);
   endtask : wr_io

   // Returns in the cycle where the one-cycle valid stands
   task automatic rd_io(input logic [9:0] a, output logic [7:0] d);
      i_vms_host_model.cycle(1'b0, {10'h000, a}, 8'h00, 1'b0);
      check("io_rvalid", {11'h000, io_rvalid}, 12'h001);
      d = io_rdata;
   endtask : rd_io

   task automatic rd_mem(input logic [19:0] a, input logic [7:0] exp);
      i_vms_host_model.cycle(1'b1, a, 8'h00, 1'b0);
      check("mem_rvalid", {11'h000, mem_rvalid}, 12'h001);
      check("mem_rdata", {4'h0, mem_rdata}, {4'h0, exp});
   endtask : rd_mem

   // Expected mode outputs; blink is meaningless once graphics is on
   function automatic logic [11:0] exp_mode(input logic [7:0] m,
                                            input logic [7:0] c);
      return {m[0], m[1], m[2], m[3], m[4], m[5] & ~m[1], c[5:0]};
   endfunction : exp_mode

   // Hang guard, far above the 137 cycles the run needs
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk_in);
      #1;
      rst_in = 1'b0;
      check("mode_reset", mode, 12'h000);
      rd_io(vms_pkg::PORT_STATUS, st);
      check("pen_reset", {11'h000, st[1]}, 12'h000);
      // Each mode: video off, colour, then the full mode byte, video on where its bit 3 is set
      for (int i = 0; i < 8; i++) begin
         wr_io(vms_pkg::PORT_MODE_SELECT, modes[i] & 8'hF7);
         wr_io(vms_pkg::PORT_COLOR_SELECT, 8'hC0 + 8'(i * 7));
         check("video_off", {11'h000, mode.video_en}, 12'h000);
         wr_io(vms_pkg::PORT_MODE_SELECT, modes[i]);
         @(posedge clk_in);
         #1;
         check("mode", mode, exp_mode(modes[i], 8'(i * 7)));
      end
      rd_io(vms_pkg::PORT_MODE_SELECT, st);
      check("mode_readback", {4'h0, st}, 12'h000);
      // Status inputs in every combination, pen latch still clear
      for (int k = 0; k < 8; k++) begin
         {crt_vretrace, crt_active, pen_switch_n} = 3'(k);
         repeat (3) @(posedge clk_in);
         #1;
         rd_io(vms_pkg::PORT_STATUS, st);
         check("status", {4'h0, st}, {8'h00, 1'(k >> 2), 1'(k),
                1'b0, ~1'(k >> 1)});
      end
      // Pen latch: edge, held after pin drops, clear, preset, clear
      pen_trigger = 1'b1;
      repeat (4) @(posedge clk_in);
      #1;
      pen_trigger = 1'b0;
      rd_io(vms_pkg::PORT_STATUS, st);
      check("pen_set", {11'h000, st[1]}, 12'h001);
      rd_io(vms_pkg::PORT_STATUS, st);
      check("pen_held", {11'h000, st[1]}, 12'h001);
      wr_io(vms_pkg::PORT_PEN_CLEAR, 8'hA5);
      rd_io(vms_pkg::PORT_STATUS, st);
      check("pen_clear", {11'h000, st[1]}, 12'h000);
      wr_io(vms_pkg::PORT_PEN_PRESET, 8'h00);
      rd_io(vms_pkg::PORT_STATUS, st);
      check("pen_preset", {11'h000, st[1]}, 12'h001);
      wr_io(vms_pkg::PORT_PEN_CLEAR, 8'h00);
      rd_io(vms_pkg::PORT_STATUS, st);
      check("pen_clear0", {11'h000, st[1]}, 12'h000);
      // Buffer edges, and a write just past the window must not alias
      i_vms_host_model.cycle(1'b1, 20'hB_8000, 8'h11, 1'b1);
      i_vms_host_model.cycle(1'b1, 20'hB_BFFF, 8'h22, 1'b1);
      i_vms_host_model.cycle(1'b1, 20'hB_C000, 8'hEE, 1'b1);
      rd_mem(20'hB_8000, 8'h11);
      rd_mem(20'hB_BFFF, 8'h22);
      i_vms_host_model.cycle(1'b1, 20'hB_C000, 8'h00, 1'b0);
      check("mem_outside", {11'h000, mem_rvalid}, 12'h000);
      disp_addr = 14'h3FFF;
      @(posedge clk_in);
      #1;
      check("disp_rdata", {4'h0, disp_rdata}, 12'h022);
      wrap_up();
   end
endmodule : tb_top
